/* verilog/cgt_timers.sv */
// four general timers with source select, capture, gating and cascading
// Function
// RQ1: each timer counts cascade, system clock, clock divided by 16, or its pin
// RQ2: four external timer input pins, one per timer
// RQ3: input capture on rising, falling or both edges
// RQ4: timer drives its output pin when count reaches reference
// RQ5: reference match gives an active-low pulse or toggles the output
// RQ6: a timer output can clock the next timer, forming 32 bits
// RQ7: each timer has a 16-bit count and 16-bit reference
// RQ8: an external gate input can gate or restart the timers
// RQ9: gate a controls timers 1 and 2, gate b timers 3 and 4
module cgt_timers
    import cgt_pkg::*;
#(
    parameter int NUM = CGT_NUM_TIMERS,
    parameter int CNT_W = CGT_CNT_W
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // pins
    input wire logic [NUM-1:0] timerInPins,
    input wire logic gate_a_in,
    input wire logic gate_b_in,
    output logic [NUM-1:0] timer_out_pins,
    // configuration per timer
    input wire logic [NUM-1:0] timerEnable,
    input wire logic [NUM-1:0] toggleMode,
    input wire logic [NUM*2-1:0] sourceSel,
    input wire logic [NUM*2-1:0] edgeSel,
    input wire logic [NUM*2-1:0] gateMode,
    input wire logic [NUM*CNT_W-1:0] refValues,
    // cascade pairs: bit 0 joins timers 1 and 2, bit 1 joins 3 and 4
    input wire logic [NUM/2-1:0] cascadePair,
    // status per timer
    output logic [NUM*CNT_W-1:0] counts,
    output logic [NUM*CNT_W-1:0] captures,
    output logic [NUM-1:0] captureEvents,
    output logic [NUM-1:0] refEvents
);
    import cgt_pkg::*;

    // ************************************************
    // pin synchronisers, prescaler and edge detect
    // ************************************************
    typedef struct packed {
        logic [NUM-1:0] pinMeta;
        logic [NUM-1:0] pinSync;
        logic [NUM-1:0] pinPrev;
        logic [1:0] gateMeta;
        logic [1:0] gateSync;
        logic [1:0] gatePrev;
        logic [3:0] prescale;
        logic div16Tick;
    } cgt_top_t;

    cgt_top_t st;
    cgt_top_t next_st;
    logic [NUM-1:0] pinRise;
    logic [NUM-1:0] pinFall;
    logic [NUM-1:0] tick;
    logic [NUM-1:0] restart;
    logic [NUM-1:0] chanEnable;
    logic [NUM-1:0] refEv;
    logic [NUM-1:0] outLvl;
    logic [1:0] gateLevel;
    logic [1:0] gateFall;

    always_comb begin
        next_st = st;
        next_st.pinMeta = timerInPins; // see RQ2
        next_st.pinSync = st.pinMeta;
        next_st.pinPrev = st.pinSync;
        next_st.gateMeta = {gate_b_in, gate_a_in};
        next_st.gateSync = st.gateMeta;
        next_st.gatePrev = st.gateSync;
        next_st.prescale = st.prescale + 4'h1;
        next_st.div16Tick = (st.prescale == 4'(CGT_PRESCALE_DIV - 5'h01)); // see RQ1
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign pinRise = st.pinSync & ~st.pinPrev;
    assign pinFall = ~st.pinSync & st.pinPrev;
    // gate inputs are active low: counting is allowed while low
    assign gateLevel = ~st.gateSync;
    assign gateFall = ~st.gateSync & st.gatePrev;

    // ************************************************
    // channels
    // ************************************************
    genvar i;
    generate
        for (i = 0; i < NUM; i++) begin : g_chan
            localparam int G = i / 2;
            logic [1:0] src;
            logic [1:0] gm;
            logic cascIn;
            logic tk;
            assign src = sourceSel[i*2 +: 2];
            assign gm = gateMode[i*2 +: 2];
            // cascade source is the previous timer's reference event
            if (i == 0) begin : g_first
                assign cascIn = refEv[NUM-1];
            end else begin : g_rest
                assign cascIn = refEv[i-1];
            end
            // each channel drives its own local tick, so no bit of tick has two processes
            always_comb begin
                if ((i % 2 == 1) && cascadePair[G]) begin
                    tk = cascIn; // see RQ6
                end else begin
                    unique case (src) // see RQ1
                        CGT_SRC_CASCADE: tk = cascIn;
                        CGT_SRC_SYSCLK: tk = 1'b1;
                        CGT_SRC_SYSDIV16: tk = st.div16Tick;
                        CGT_SRC_PIN: tk = pinRise[i];
                    endcase
                end
            end
            assign tick[i] = tk;
            // gate a serves timers 1-2, gate b serves 3-4
            assign chanEnable[i] = timerEnable[i]
                && !(gm == CGT_GATE_LEVEL && !gateLevel[G]); // see RQ9
            assign restart[i] = (gm == CGT_GATE_RESTART) && gateFall[G]; // see RQ8
            cgt_timer #(
                .CNT_W(CNT_W)
            ) u_timer (
                .clk_sys(clk_sys),
                .reset(reset),
                .enable(chanEnable[i]),
                .toggleMode(toggleMode[i]),
                .edgeSel(edgeSel[i*2 +: 2]),
                .refValue(refValues[i*CNT_W +: CNT_W]),
                .tick(tick[i]),
                .restart(restart[i]),
                .pinRise(pinRise[i]),
                .pinFall(pinFall[i]),
                .count(counts[i*CNT_W +: CNT_W]),
                .capture(captures[i*CNT_W +: CNT_W]),
                .captureEvent(captureEvents[i]),
                .refEvent(refEv[i]),
                .outLevel(outLvl[i])
            );
        end
    endgenerate

    assign refEvents = refEv;
    assign timer_out_pins = outLvl; // see RQ4
endmodule

/* verilog/cgt_pkg.sv */
// package of constants for the cascadable general timers
package cgt_pkg;
    // ************************************************
    // sizes and encodings
    // ************************************************
    localparam int CGT_NUM_TIMERS = 4;
    localparam int CGT_CNT_W = 16;
    localparam logic [4:0] CGT_PRESCALE_DIV = 5'h10;
    localparam logic [15:0] CGT_CNT_RESET = 16'h0000;
    localparam logic [15:0] CGT_REF_RESET = 16'hFFFF;

    // count source select
    localparam logic [1:0] CGT_SRC_CASCADE = 2'h0;
    localparam logic [1:0] CGT_SRC_SYSCLK = 2'h1;
    localparam logic [1:0] CGT_SRC_SYSDIV16 = 2'h2;
    localparam logic [1:0] CGT_SRC_PIN = 2'h3;

    // capture edge select
    localparam logic [1:0] CGT_EDGE_NONE = 2'h0;
    localparam logic [1:0] CGT_EDGE_RISE = 2'h1;
    localparam logic [1:0] CGT_EDGE_FALL = 2'h2;
    localparam logic [1:0] CGT_EDGE_BOTH = 2'h3;

    // gate mode
    localparam logic [1:0] CGT_GATE_OFF = 2'h0;
    localparam logic [1:0] CGT_GATE_LEVEL = 2'h1;
    localparam logic [1:0] CGT_GATE_RESTART = 2'h2;
endpackage

/* verilog/cgt_timer.sv */
// one 16-bit timer channel with capture, reference compare and output control
module cgt_timer
    import cgt_pkg::*;
#(
    parameter int CNT_W = CGT_CNT_W
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // configuration
    input wire logic enable,
    input wire logic toggleMode,
    input wire logic [1:0] edgeSel,
    input wire logic [CNT_W-1:0] refValue,
    // events
    input wire logic tick,
    input wire logic restart,
    input wire logic pinRise,
    input wire logic pinFall,
    // results
    output logic [CNT_W-1:0] count,
    output logic [CNT_W-1:0] capture,
    output logic captureEvent,
    output logic refEvent,
    output logic outLevel
);
    import cgt_pkg::*;

    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic [CNT_W-1:0] capture;
        logic captureEvent;
        logic refEvent;
        logic outLevel;
    } cgt_chan_t;

    cgt_chan_t st;
    cgt_chan_t next_st;
    logic capHit;
    logic refHit;

    always_comb begin
        next_st = st;
        next_st.captureEvent = 1'b0;
        next_st.refEvent = 1'b0;
        capHit = (pinRise && (edgeSel == CGT_EDGE_RISE || edgeSel == CGT_EDGE_BOTH))
            || (pinFall && (edgeSel == CGT_EDGE_FALL || edgeSel == CGT_EDGE_BOTH)); // see RQ3
        // a restart wins over a match, so the output and the event never disagree
        refHit = enable && tick && !restart && (st.count == refValue); // see RQ4
        if (capHit) begin
            next_st.capture = st.count;
            next_st.captureEvent = 1'b1;
        end
        if (restart) begin
            next_st.count = CGT_CNT_RESET; // see RQ8
        end else if (refHit) begin
            next_st.count = CGT_CNT_RESET;
            next_st.refEvent = 1'b1;
        end else if (enable && tick) begin
            next_st.count = st.count + 1'b1; // see RQ7
        end
        // toggle flips the held level; pulse mode idles high and dips for one cycle
        if (toggleMode) begin
            if (refHit) begin
                next_st.outLevel = ~st.outLevel; // see RQ5
            end
        end else begin
            next_st.outLevel = ~refHit; // see RQ5
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            st <= '{count: CGT_CNT_RESET, capture: CGT_CNT_RESET, captureEvent: 1'b0,
                    refEvent: 1'b0, outLevel: 1'b1};
        end else begin
            st <= next_st;
        end
    end

    assign count = st.count;
    assign capture = st.capture;
    assign captureEvent = st.captureEvent;
    assign refEvent = st.refEvent;
    assign outLevel = st.outLevel;
endmodule

/* sim/cgt_timers_assertions.sv */
// concurrent checks on the ports of the general timers
module cgt_timers_assertions
    import cgt_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic gate_b_in,
    input wire logic [3:0] timer_out_pins,
    input wire logic [3:0] timerEnable,
    input wire logic [3:0] toggleMode,
    input wire logic [7:0] sourceSel,
    input wire logic [7:0] gateMode,
    input wire logic [63:0] refValues,
    input wire logic [63:0] counts,
    input wire logic [63:0] captures,
    input wire logic [3:0] captureEvents,
    input wire logic [3:0] refEvents
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    pulse_low_a: assert property (((timer_out_pins ^ refEvents) | toggleMode) == 4'hF)
        else $error("pulse output wrong");
    toggle_flip_a: assert property (
        ((timer_out_pins ^ $past(timer_out_pins)) & toggleMode) == (refEvents & toggleMode))
        else $error("toggle output wrong");
    wrap_zero_a: assert property (refEvents[0] |->
        counts[15:0] == 16'h0000 && $past(counts[15:0]) == refValues[15:0])
        else $error("match not at reference");
    count_step_a: assert property (timerEnable[0] && sourceSel[1:0] == CGT_SRC_SYSCLK
        && gateMode[1:0] == CGT_GATE_OFF && counts[15:0] != refValues[15:0]
        |=> counts[15:0] == $past(counts[15:0]) + 16'h0001) else $error("no clock step");
    hold_off_a: assert property (!timerEnable[2] && gateMode[5:4] == CGT_GATE_OFF
        |=> $stable(counts[47:32])) else $error("disabled timer moved");
    div_slow_a: assert property (timerEnable[2] && sourceSel[5:4] == CGT_SRC_SYSDIV16
        && gateMode[5:4] == CGT_GATE_OFF && $changed(counts[47:32])
        |=> $stable(counts[47:32])[*8]) else $error("divided tick too fast");
    gate_hold_a: assert property ((gate_b_in && gateMode[5:4] == CGT_GATE_LEVEL)[*4]
        |=> $stable(counts[47:32])) else $error("gated timer moved");
    capture_val_a: assert property (captureEvents[3] |->
        captures[63:48] == $past(counts[63:48])) else $error("capture value wrong");
endmodule

bind cgt_timers cgt_timers_assertions u_chk (.clk_sys(clk_sys), .reset(reset),
    .gate_b_in(gate_b_in), .timer_out_pins(timer_out_pins), .timerEnable(timerEnable),
    .toggleMode(toggleMode), .sourceSel(sourceSel), .gateMode(gateMode),
    .refValues(refValues), .counts(counts), .captures(captures),
    .captureEvents(captureEvents), .refEvents(refEvents));

/* sim/cgt_pin_src.sv */
// outside sources for the timer input pins and the two gate inputs
module cgt_pin_src (
    // clock
    input wire logic clk_sys,
    // driven lines
    output logic [3:0] pins,
    output logic gateA,
    output logic gateB
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        pins = 4'h0;
        gateA = 1'b0;
        gateB = 1'b1;
    end
    // each level stays 4 cycles, longer than the pin synchroniser needs
    task automatic burst(input int idx, input int n);
        repeat (n) begin
            repeat (4) @(negedge clk_sys);
            pins[idx] = 1'b1;
            repeat (4) @(negedge clk_sys);
            pins[idx] = 1'b0;
        end
    endtask
    task automatic gate(input logic a, input logic b);
        @(negedge clk_sys);
        gateA = a;
        gateB = b;
    endtask
endmodule

/* sim/cgt_timers_tb.sv */
// self-checking bench for the general timers
module cgt_timers_tb;
    import cgt_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
`define CK(a, e) begin comparisons++; if ((a) !== (e)) begin errors++; \
    $display("[ERR] %0t got %0h exp %0h", $time, a, e); end end
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [3:0] timerInPins, timer_out_pins, captureEvents, refEvents;
    logic [3:0] timerEnable = 4'hF, toggleMode = 4'hA;
    logic gate_a_in, gate_b_in;
    logic [7:0] sourceSel = 8'h55, edgeSel = 8'h00, gateMode = 8'h00;
    logic [63:0] refValues = 64'hFFFF, counts, captures;
    logic [1:0] cascadePair = 2'b00;
    int errors = 0, comparisons = 0, evCnt = 0, capCnt = 0;
    always #12.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        evCnt <= evCnt + int'(refEvents[0]);
        capCnt <= capCnt + int'(captureEvents[3]);
    end
    cgt_pin_src u_src (.clk_sys(clk_sys), .pins(timerInPins), .gateA(gate_a_in),
        .gateB(gate_b_in));
    cgt_timers u_dut (.clk_sys(clk_sys), .reset(reset), .timerInPins(timerInPins),
        .gate_a_in(gate_a_in), .gate_b_in(gate_b_in), .timer_out_pins(timer_out_pins),
        .timerEnable(timerEnable), .toggleMode(toggleMode), .sourceSel(sourceSel),
        .edgeSel(edgeSel), .gateMode(gateMode), .refValues(refValues),
        .cascadePair(cascadePair), .counts(counts), .captures(captures),
        .captureEvents(captureEvents), .refEvents(refEvents));
    // cfg changes source, gate, reference, cascade and enable only under reset; the loop sets edgeSel a cycle before reset rises
    task automatic cfg(input logic [7:0] s, input logic [7:0] g, input logic [63:0] r,
                       input logic [1:0] c, input logic [3:0] e);
        @(negedge clk_sys);
        reset = 1'b1;
        {sourceSel, gateMode, refValues, cascadePair, timerEnable} = {s, g, r, c, e};
        evCnt = 0;
        capCnt = 0;
        repeat (3) @(negedge clk_sys);
        reset = 1'b0;
    endtask
    task automatic end_sim();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        for (int m = 0; m < 4; m++) begin
            edgeSel = {m[1:0], 6'h00};
            cfg(8'hE1, 8'h00, 64'hFFFF_0004_0004_0002, 2'b00, 4'hF);
            u_src.burst(3, 5);
            repeat (12) @(negedge clk_sys);
            `CK(counts[15:0], 16'h0001)
            `CK(counts[31:16], 16'h0002)
            `CK(timer_out_pins[1], 1'b0)
            `CK(counts[47:32], 16'h0003)
            `CK(evCnt, 17)
            `CK(counts[63:48], 16'h0005)
            `CK(capCnt, (m[0] ? 5 : 0) + (m[1] ? 5 : 0))
            `CK(captures[63:48], (m == 1) ? 16'h0004 : ((m == 0) ? 16'h0000 : 16'h0005))
        end
        cfg(8'h51, 8'h10, 64'hFFFF_FFFF_FFFF_0003, 2'b01, 4'hF);
        repeat (42) @(negedge clk_sys);
        `CK(counts[31:16], 16'h000A)
        `CK(counts[47:32], 16'h0002)
        `CK(counts[63:48], 16'h002A)
        cfg(8'h55, 8'h02, 64'hFFFF_FFFF_FFFF_FFFF, 2'b00, 4'hB);
        u_src.gate(1'b1, 1'b1);
        repeat (20) @(negedge clk_sys);
        u_src.gate(1'b0, 1'b1);
        repeat (10) @(negedge clk_sys);
        `CK(counts[15:0], 16'h0007)
        `CK(counts[31:16], 16'h0020)
        `CK(counts[47:32], 16'h0000)
        end_sim();
    end
endmodule
